// *** design/msc_sideband.v ***
// sideband control: select gating, reset filter, power mode entry, presence
//
// Operation
// RL1: low power after plug/reset if request asserted
// RL2: otherwise proceed to high power unaided
// RL3: select low lets the 2-wire slave answer
// RL4: select high: no answer, no acknowledge
// RL5: host waits deassert time after deselect
// RL6: host waits assert time after select
// RL7: long reset low restores all defaults
// RL8: undriven reset input reads high
// RL9: undriven low-power input reads asserted
// RL10: presence output low while inserted
// RL11: data moves only while clock low
// RL12: waits and reset length are parameters
`timescale 1ns/1ps
`default_nettype none
`include "msc_defs.vh"

module msc_sideband #(
	parameter integer RESET_MIN_CYC = `MSC_RESET_MIN_CYC,
	parameter integer SEL_ASSERT_CYC = `MSC_SEL_ASSERT_CYC,
	parameter integer SEL_DEASSERT_CYC = `MSC_SEL_DEASSERT_CYC
) (
	input wire CLK,
	input wire RST,
	input wire MODULE_SELECT_N,
	input wire MODULE_RESET_N,
	input wire MODULE_RESET_N_DRIVEN,
	input wire LOW_POWER_REQUEST,
	input wire LOW_POWER_REQUEST_DRIVEN,
	output reg MODULE_PRESENT_N,
	input wire SCL_IN,
	input wire SDA_IN,
	output wire SDA_OUT,
	output wire SDA_OE,
	input wire SLAVE_SDA_OE,
	output reg SLAVE_ENABLE,
	output reg SLAVE_START,
	output reg SLAVE_STOP,
	output reg SLAVE_SCL_RISE,
	output reg SLAVE_SDA,
	output reg DEFAULTS_LOAD,
	output reg LOW_POWER_MODE,
	output reg HIGH_POWER_MODE
);

	// ----------------------------------------------------------------
	// pin input resolution and synchronisation
	// ----------------------------------------------------------------

	wire [6:0] sync_q;
	wire select_n;
	wire reset_n;
	wire low_power;
	wire scl;
	wire sda;

	// every pin, drive flags too, passes two flops before logic reads it
	msc_sync #(
		.W(7),
		.RESET_VALUE(`MSC_SYNC_RESET)
	) u_sync (
		.clk(CLK),
		.rst(RST),
		.d({MODULE_SELECT_N, MODULE_RESET_N, MODULE_RESET_N_DRIVEN, LOW_POWER_REQUEST,
			LOW_POWER_REQUEST_DRIVEN, SCL_IN, SDA_IN}),
		.q(sync_q)
	);

	// internal pull-ups stand in when the host leaves the reset or low-power pin floating
	assign select_n = sync_q[6];
	assign reset_n = sync_q[4] ? sync_q[5] : `MSC_PULL_UP; // [RL8]
	assign low_power = sync_q[2] ? sync_q[3] : `MSC_PULL_UP; // [RL9]
	assign scl = sync_q[1];
	assign sda = sync_q[0];

	// ----------------------------------------------------------------
	// presence
	// ----------------------------------------------------------------

	// presence pin is a tie to ground whenever the module is seated
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			MODULE_PRESENT_N <= 1'b0;
		end else begin
			MODULE_PRESENT_N <= 1'b0; // [RL10]
		end
	end

	// ----------------------------------------------------------------
	// reset pulse filter
	// ----------------------------------------------------------------

	reg [`MSC_CNT_W-1:0] rst_cnt;
	reg rst_armed;
	wire rst_long;

	assign rst_long = (rst_cnt >= RESET_MIN_CYC[`MSC_CNT_W-1:0]);

	// count low time; short glitches do nothing
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			rst_cnt <= {`MSC_CNT_W{1'b0}};
			rst_armed <= 1'b0;
			DEFAULTS_LOAD <= 1'b0;
		end else begin
			DEFAULTS_LOAD <= 1'b0;
			if (reset_n) begin
				rst_cnt <= {`MSC_CNT_W{1'b0}};
				rst_armed <= 1'b0;
			end else begin
				if (!rst_long) begin
					rst_cnt <= rst_cnt + 1'b1; // [RL12]
				end
				if (rst_long && !rst_armed) begin
					rst_armed <= 1'b1;
					DEFAULTS_LOAD <= 1'b1; // [RL7]
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// power mode state machine
	// ----------------------------------------------------------------

	localparam ST_RESET = `MSC_ST_RESET;
	localparam ST_EVAL = `MSC_ST_EVAL;
	localparam ST_LOW = `MSC_ST_LOW;
	localparam ST_HIGH = `MSC_ST_HIGH;

	reg [3:0] state;
	reg [3:0] next_state;

	// entry from power-up or full reset is decided by the request level
	always @* begin
		next_state = state;
		case (state)
			ST_RESET: begin
				if (!rst_armed) begin
					next_state = ST_EVAL;
				end
			end
			ST_EVAL: begin
				if (low_power) begin
					next_state = ST_LOW; // [RL1]
				end else begin
					next_state = ST_HIGH; // [RL2]
				end
			end
			ST_LOW: begin
				if (!low_power) begin
					next_state = ST_HIGH;
				end
			end
			ST_HIGH: begin
				if (low_power) begin
					next_state = ST_LOW;
				end
			end
			default: begin
				next_state = ST_RESET;
			end
		endcase
		if (rst_armed) begin
			next_state = ST_RESET; // [RL7]
		end
	end

	// low power is the safe choice while held in reset
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			state <= ST_RESET;
			LOW_POWER_MODE <= 1'b1;
			HIGH_POWER_MODE <= 1'b0;
		end else begin
			state <= next_state;
			LOW_POWER_MODE <= (next_state != ST_HIGH);
			HIGH_POWER_MODE <= (next_state == ST_HIGH);
		end
	end

	// ----------------------------------------------------------------
	// select gating of the 2-wire slave
	// ----------------------------------------------------------------

	reg [`MSC_CNT_W-1:0] sel_cnt;
	reg scl_d;
	reg sda_d;

	// answer only after the select-assert wait; drop at once on deselect
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			sel_cnt <= {`MSC_CNT_W{1'b0}};
			SLAVE_ENABLE <= 1'b0;
		end else begin
			if (select_n || rst_armed) begin
				sel_cnt <= {`MSC_CNT_W{1'b0}};
				SLAVE_ENABLE <= 1'b0; // [RL4]
			end else if (sel_cnt < SEL_ASSERT_CYC[`MSC_CNT_W-1:0]) begin
				sel_cnt <= sel_cnt + 1'b1; // [RL12]
				SLAVE_ENABLE <= 1'b0; // [RL6]
			end else begin
				SLAVE_ENABLE <= 1'b1; // [RL3]
			end
		end
	end

	// bus events: data edge with clock high is start or stop
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			SLAVE_START <= 1'b0;
			SLAVE_STOP <= 1'b0;
			SLAVE_SCL_RISE <= 1'b0;
			SLAVE_SDA <= 1'b1;
		end else begin
			scl_d <= scl;
			sda_d <= sda;
			SLAVE_SDA <= sda;
			SLAVE_START <= SLAVE_ENABLE && scl && scl_d && sda_d && !sda; // [RL11]
			SLAVE_STOP <= SLAVE_ENABLE && scl && scl_d && !sda_d && sda; // [RL11]
			SLAVE_SCL_RISE <= SLAVE_ENABLE && scl && !scl_d;
		end
	end

	// open-drain data: only ever pull low, and only while selected
	assign SDA_OUT = 1'b0;
	assign SDA_OE = SLAVE_SDA_OE && SLAVE_ENABLE && !select_n; // [RL4]

	// deselect wait is the host's to keep; no logic needed on this side

endmodule // msc_sideband

`default_nettype wire

// *** design/msc_defs.vh ***
// timing constants and state codes for the module sideband control block
`ifndef MSC_DEFS_VH
`define MSC_DEFS_VH

// clock period of CLK in ns (20 MHz)
`define MSC_CLK_PERIOD_NS 50
// least low time on the reset input that starts a full reset, in ns
`define MSC_RESET_MIN_NS 10000
// time after select before the 2-wire slave answers, in ns
`define MSC_SEL_ASSERT_NS 2000
// time after deselect before the host may use the bus, in ns
`define MSC_SEL_DEASSERT_NS 2000
// derived cycle counts, rounded up (least times)
`define MSC_RESET_MIN_CYC ((`MSC_RESET_MIN_NS + `MSC_CLK_PERIOD_NS - 1) / `MSC_CLK_PERIOD_NS)
`define MSC_SEL_ASSERT_CYC ((`MSC_SEL_ASSERT_NS + `MSC_CLK_PERIOD_NS - 1) / `MSC_CLK_PERIOD_NS)
`define MSC_SEL_DEASSERT_CYC ((`MSC_SEL_DEASSERT_NS + `MSC_CLK_PERIOD_NS - 1) / `MSC_CLK_PERIOD_NS)
// counter width for the timing counters
`define MSC_CNT_W 16
// power state codes, one-hot
`define MSC_ST_RESET 4'h1
`define MSC_ST_EVAL 4'h2
`define MSC_ST_LOW 4'h4
`define MSC_ST_HIGH 4'h8
// resolved level of a pulled-up input that nobody drives
`define MSC_PULL_UP 1'b1
// reset value of the pin synchroniser: idle high, pins counted as driven
`define MSC_SYNC_RESET 7'h7F

`endif

// *** design/msc_sync.v ***
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none

module msc_sync #(
	parameter W = 1,
	parameter [W-1:0] RESET_VALUE = {W{1'b1}}
) (
	input wire clk,
	input wire rst,
	input wire [W-1:0] d,
	output reg [W-1:0] q
);

	reg [W-1:0] meta;

	// first stage feeds only the second stage
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= RESET_VALUE;
			q <= RESET_VALUE;
		end else begin
			meta <= d;
			q <= meta;
		end
	end

endmodule // msc_sync

`default_nettype wire

// *** test/msc_sideband_checker.sv ***
// assertion checker for the sideband control block
`timescale 1ns/1ps
`default_nettype none
// ----------
// checker
// ----------
module msc_sideband_checker #(
	parameter integer RESET_MIN_CYC = 4,
	parameter integer SEL_ASSERT_CYC = 4
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic MODULE_SELECT_N,
	input wire logic MODULE_RESET_N,
	input wire logic MODULE_RESET_N_DRIVEN,
	input wire logic LOW_POWER_REQUEST,
	input wire logic LOW_POWER_REQUEST_DRIVEN,
	input wire logic MODULE_PRESENT_N,
	input wire logic SDA_OE,
	input wire logic SLAVE_SDA_OE,
	input wire logic SLAVE_ENABLE,
	input wire logic DEFAULTS_LOAD,
	input wire logic LOW_POWER_MODE,
	input wire logic HIGH_POWER_MODE
);
	// pin levels as the module resolves them
	wire rst_lo = !MODULE_RESET_N && MODULE_RESET_N_DRIVEN;
	wire lp_on = LOW_POWER_REQUEST || !LOW_POWER_REQUEST_DRIVEN;
	wire sel_on = !MODULE_SELECT_N && !rst_lo;
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	a_present_low: assert property (!MODULE_PRESENT_N) else $error("present high");
	a_mode_onehot: assert property (LOW_POWER_MODE != HIGH_POWER_MODE) else $error("modes");
	a_low_follow: assert property (lp_on[*8] |-> LOW_POWER_MODE) else $error("low mode");
	a_high_follow: assert property ((!lp_on && !rst_lo)[*8] |-> HIGH_POWER_MODE)
		else $error("high mode");
	a_reset_low: assert property (rst_lo[*8] |=> LOW_POWER_MODE) else $error("reset mode");
	a_short_ignored: assert property ((!rst_lo)[*4] |-> !DEFAULTS_LOAD) else $error("load");
	a_load_cause: assert property (DEFAULTS_LOAD |-> $past(rst_lo, RESET_MIN_CYC) ##1 !DEFAULTS_LOAD)
		else $error("load cause");
	a_desel_quiet: assert property (MODULE_SELECT_N[*4] |-> !SLAVE_ENABLE && !SDA_OE)
		else $error("deselected answer");
	a_sel_wait: assert property ($rose(SLAVE_ENABLE) |-> !$past(MODULE_SELECT_N, SEL_ASSERT_CYC))
		else $error("early enable");
	a_sel_answer: assert property (sel_on[*8] ##1 sel_on[*4] |-> SLAVE_ENABLE)
		else $error("no enable");
	a_oe_gated: assert property (SDA_OE |-> SLAVE_SDA_OE && SLAVE_ENABLE) else $error("oe");
endmodule // msc_sideband_checker

bind msc_sideband msc_sideband_checker #(.RESET_MIN_CYC(RESET_MIN_CYC),
	.SEL_ASSERT_CYC(SEL_ASSERT_CYC)) u_chk (.CLK(CLK), .RST(RST),
	.MODULE_SELECT_N(MODULE_SELECT_N), .MODULE_RESET_N(MODULE_RESET_N),
	.MODULE_RESET_N_DRIVEN(MODULE_RESET_N_DRIVEN), .LOW_POWER_REQUEST(LOW_POWER_REQUEST),
	.LOW_POWER_REQUEST_DRIVEN(LOW_POWER_REQUEST_DRIVEN), .MODULE_PRESENT_N(MODULE_PRESENT_N),
	.SDA_OE(SDA_OE), .SLAVE_SDA_OE(SLAVE_SDA_OE), .SLAVE_ENABLE(SLAVE_ENABLE),
	.DEFAULTS_LOAD(DEFAULTS_LOAD), .LOW_POWER_MODE(LOW_POWER_MODE),
	.HIGH_POWER_MODE(HIGH_POWER_MODE));
`default_nettype wire

// *** test/msc_host.sv ***
// host 2-wire master model, one frame per request
`timescale 1ns/1ps
`default_nettype none
module msc_host (
	input wire logic clk,
	input wire logic go,
	input wire logic dev_oe,
	output logic scl,
	output logic sda,
	output logic busy
);
	logic run = 1'b0;
	logic [5:0] ph = 6'h00;
	logic [5:0] q;
	logic [5:0] s;
	// frame sequencer, one phase per clock
	always @(posedge clk) begin
		if (go && !run) run <= 1'b1;
		else if (ph == 6'h25) run <= 1'b0;
		ph <= run ? ph + 6'h01 : 6'h00;
	end
	// start, 8 bits, a ninth clock with sda low, stop; data moves while scl low
	always_comb begin
		q = ph - 6'h02;
		s = ph - 6'h03;
		scl = !(run && ph >= 6'h02 && ph <= 6'h23 && !q[1]);
		sda = !run || ph == 6'h00 || ph == 6'h25 || (ph >= 6'h03 && ph <= 6'h22 && s[4:2] != 3'h1
			&& s[4:2] != 3'h3 && s[4:2] != 3'h4 && s[4:2] != 3'h6);
		sda = sda && !dev_oe; // wired-and with the module
	end
	assign busy = run;
endmodule // msc_host
`default_nettype wire

// *** test/msc_sideband_bench.sv ***
// self-checking bench for the sideband control block
`timescale 1ns/1ps
`default_nettype none
module msc_sideband_bench;
	localparam integer RMIN = 4;
	localparam integer RSEL = 4;
	localparam logic [7:0] HOST_BYTE = 8'hA5; // bit pattern the host model sends
	logic [8:0] rx = 9'h000;
	logic CLK = 0, RST = 1, MODULE_SELECT_N = 1, MODULE_RESET_N = 1, MODULE_RESET_N_DRIVEN = 1;
	logic LOW_POWER_REQUEST = 1, LOW_POWER_REQUEST_DRIVEN = 0, SLAVE_SDA_OE = 0, go = 0;
	wire SCL_IN, SDA_IN, SDA_OUT, SDA_OE, MODULE_PRESENT_N, SLAVE_ENABLE, SLAVE_START;
	wire SLAVE_STOP, SLAVE_SCL_RISE, SLAVE_SDA, DEFAULTS_LOAD, LOW_POWER_MODE, HIGH_POWER_MODE;
	wire busy;
	int bad_count = 0, tests_run = 0, st_n = 0, sp_n = 0, rs_n = 0, dl_n = 0, a, b, c;
	logic [31:0] seed = 32'h17ED;
	msc_sideband #(.RESET_MIN_CYC(RMIN), .SEL_ASSERT_CYC(RSEL), .SEL_DEASSERT_CYC(RSEL)) u_dut (
		.CLK(CLK), .RST(RST), .MODULE_SELECT_N(MODULE_SELECT_N), .MODULE_RESET_N(MODULE_RESET_N),
		.MODULE_RESET_N_DRIVEN(MODULE_RESET_N_DRIVEN), .LOW_POWER_REQUEST(LOW_POWER_REQUEST),
		.LOW_POWER_REQUEST_DRIVEN(LOW_POWER_REQUEST_DRIVEN), .MODULE_PRESENT_N(MODULE_PRESENT_N),
		.SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
		.SLAVE_SDA_OE(SLAVE_SDA_OE), .SLAVE_ENABLE(SLAVE_ENABLE), .SLAVE_START(SLAVE_START),
		.SLAVE_STOP(SLAVE_STOP), .SLAVE_SCL_RISE(SLAVE_SCL_RISE), .SLAVE_SDA(SLAVE_SDA),
		.DEFAULTS_LOAD(DEFAULTS_LOAD), .LOW_POWER_MODE(LOW_POWER_MODE),
		.HIGH_POWER_MODE(HIGH_POWER_MODE));
	msc_host u_host (.clk(CLK), .go(go), .dev_oe(SDA_OE), .scl(SCL_IN), .sda(SDA_IN), .busy(busy));
	// ----------
	// helpers
	// ----------
	initial forever #25 CLK = ~CLK;
	// count pulses, sampled away from the edge
	always @(negedge CLK) begin
		st_n += SLAVE_START;
		sp_n += SLAVE_STOP;
		rs_n += SLAVE_SCL_RISE;
		dl_n += DEFAULTS_LOAD;
		if (SLAVE_SCL_RISE) rx = {rx[7:0], SLAVE_SDA};
	end
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	function automatic logic exp_low(input logic [1:0] v);
		return v[0] | !v[1];
	endfunction
	task automatic wt(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask
	task automatic chk(input logic ok, input string m);
		tests_run++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("wrong value %0t %s", $time, m);
		end
	endtask
	task automatic finish_test;
		if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		bad_count++;
		finish_test();
	end
	// ----------
	// scenarios
	// ----------
	initial begin
		wt(5);
		@(posedge CLK) RST <= 1'b0;
		wt(8);
		chk(MODULE_PRESENT_N === 1'b0 && LOW_POWER_MODE === 1'b1, "floating lp");
		repeat (20) begin
			seed = xs(seed);
			@(posedge CLK) {LOW_POWER_REQUEST_DRIVEN, LOW_POWER_REQUEST} <= seed[1:0];
			wt(8);
			chk(LOW_POWER_MODE === exp_low(seed[1:0]) && HIGH_POWER_MODE === !exp_low(seed[1:0]),
				"power mode");
		end
		@(posedge CLK) {LOW_POWER_REQUEST_DRIVEN, LOW_POWER_REQUEST} <= 2'h2;
		for (int i = 0; i < 3; i++) begin
			a = dl_n;
			@(posedge CLK) {MODULE_RESET_N_DRIVEN, MODULE_RESET_N} <= {i != 2, 1'b0};
			wt(i == 0 ? RMIN - 1 : RMIN + 6);
			@(posedge CLK) {MODULE_RESET_N_DRIVEN, MODULE_RESET_N} <= 2'h3;
			wt(8);
			chk(dl_n - a === int'(i == 1) && HIGH_POWER_MODE === 1'b1, "full reset");
		end
		for (int i = 0; i < 2; i++) begin
			@(posedge CLK) MODULE_SELECT_N <= !i;
			wt(RSEL + 8); // host honours select waits
			a = st_n;
			b = sp_n;
			c = rs_n;
			@(posedge CLK) go <= 1'b1;
			@(posedge CLK) go <= 1'b0;
			wt(45);
			chk(st_n - a == i && sp_n - b == i && rs_n - c == 9 * i && !busy, "frame");
			chk(i == 0 || rx === {HOST_BYTE, 1'b0}, "frame data");
			repeat (4) begin
				seed = xs(seed);
				@(posedge CLK) SLAVE_SDA_OE <= seed[0];
				wt(1);
				chk(SDA_OE === (seed[0] & i[0]) && SDA_OUT === 1'b0, "sda drive");
			end
			@(posedge CLK) SLAVE_SDA_OE <= 1'b0;
		end
		@(posedge CLK) RST <= 1'b1;
		wt(1);
		chk(LOW_POWER_MODE === 1'b1 && SLAVE_ENABLE === 1'b0, "mid reset");
		@(posedge CLK) RST <= 1'b0;
		wt(12);
		chk(HIGH_POWER_MODE === 1'b1 && SLAVE_ENABLE === 1'b1, "after reset");
		finish_test();
	end
endmodule // msc_sideband_bench
`default_nettype wire
